// ===== shader_export_consts.vh
// Purpose: shared constants of the shader export unit
// Assumes: included by the export unit and its queue
// Notes:   definitions only
`ifndef SHADER_EXPORT_CONSTS_VH
`define SHADER_EXPORT_CONSTS_VH

// instruction field widths, lane count, data and counter widths
`define TGT_W        6
`define REG_IDX_W    8
`define LANES        8
`define LANE_W       3
`define COMP_W       32
`define HALF_W       16
`define DATA_W       128
`define CNT_W        5

// descriptor layout in the queue: {target, valid mask, final, half, register}
`define DESC_W       17
`define DESC_TGT_HI  16
`define DESC_TGT_LO  11
`define DESC_VM      10
`define DESC_DONE    9
`define DESC_HALF    8
`define DESC_REG_HI  7
`define DESC_REG_LO  0

// queue shape
`define QUEUE_DEPTH  16
`define QUEUE_AW     4

// target code boundaries
`define TGT_COLOUR_LAST 6'h07
`define TGT_DEPTH       6'h08
`define TGT_NULL        6'h09
`define TGT_POS_FIRST   6'h0C
`define TGT_POS_LAST    6'h10
`define TGT_PRIM        6'h14
`define TGT_PARAM_FIRST 6'h20

// decoded target classes
`define CLS_COLOUR   3'h0
`define CLS_DEPTH    3'h1
`define CLS_NULL     3'h2
`define CLS_POS      3'h3
`define CLS_PRIM     3'h4
`define CLS_PARAM    3'h5
`define CLS_BAD      3'h7

// engine states
`define ST_IDLE      2'h0
`define ST_REQ       2'h1
`define ST_SEND      2'h2
`define ST_FIN       2'h3

`endif

// ===== export_queue.v
// Purpose: FIFO of export descriptors between issue and the bus engine
// Assumes: single clock, asynchronous active-low reset
// Notes:   ready on the filling side is registered so it can leave the top directly
`timescale 1ns/1ns
`include "shader_export_consts.vh"

module export_queue #(
    parameter WIDTH = `DESC_W,
    parameter DEPTH = `QUEUE_DEPTH,
    parameter AW    = `QUEUE_AW
) (
    // clock and reset
    input  wire             clk,
    input  wire             arst_n,
    // filling side
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    // draining side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_reg;
    reg  [AW-1:0]    rd_ptr_reg;
    reg  [AW:0]      count_reg;
    wire             push;
    wire             pop;
    wire [AW:0]      count_next;

    assign push       = in_valid & in_ready;
    assign pop        = out_valid & out_ready;
    assign out_valid  = (count_reg != {(AW+1){1'b0}});
    assign out_data   = mem[rd_ptr_reg];
    assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // storage needs no reset; only written entries are ever read
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointers, fill level and the registered full indication
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
            in_ready   <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            in_ready  <= (count_next < DEPTH); // honest full, taken from the next fill level so never late
        end
    end
endmodule

// ===== shader_export_unit.v
// Purpose: export unit copying per-lane register data to the output buffer
// Assumes: sequencer, register file and buses share clk; register reads answer in the strobe's own cycle
// Notes:   one engine drains a 16-deep queue, so every export completes in issue order
//          the lane mask is sampled at grant, so programs must wait on the count
//          unmapped target codes are dropped and flagged on bad_target_reg
//          half precision keeps the low half of each component, packed low
//
// Summary of operation
// - decode 6-bit target: colour 0-7, depth 8, null 9, position 12-16, prim 20, params 32-63
// - with the valid mask flag, the lane-enable mask becomes the pixel valid mask
// - final flag marks last pixel or position export; ignored for parameters
// - half precision flag means 16-bit components, otherwise 32-bit
// - colour exports carry up to four components; depth may also be exported
// - only lanes enabled in the lane-enable mask write the output buffer
// - output buffer accumulates successive exports, nothing earlier is discarded
// - valid mask exports tell the colour buffer the valid pixels; last wins
// - null target updates the valid mask but sends no data
// - on selection add one to the pending count and request the bus; the bus is requested only once the engine takes the descriptor from the queue
// - on grant sample the mask, send data, subtract one after last data
// - several exports may be outstanding; same-type exports complete in order
// - with export suppress set every export instruction acts as a no-operation
`timescale 1ns/1ns
`include "shader_export_consts.vh"

module shader_export_unit (
    // clock and reset
    input  wire                  clk,
    input  wire                  arst_n,
    // export instructions from the sequencer
    input  wire                  instr_valid,
    output wire                  instr_ready,
    input  wire [`TGT_W-1:0]     instr_target,
    input  wire                  instr_valid_mask_flag,
    input  wire                  instr_final_flag,
    input  wire                  instr_half_precision_flag,
    input  wire [`REG_IDX_W-1:0] instr_reg_idx,
    // program state
    input  wire [`LANES-1:0]     lane_enable_mask,
    input  wire                  export_suppress,
    output reg  [`CNT_W-1:0]     export_pending_count_reg,
    output reg                   bad_target_reg,
    // internal bus arbitration
    output reg                   bus_req_reg,
    input  wire                  bus_gnt,
    // register file read port
    output reg                   reg_rd_en_reg,
    output reg  [`REG_IDX_W-1:0] reg_rd_idx_reg,
    output reg  [`LANE_W-1:0]    reg_rd_lane_reg,
    input  wire [`DATA_W-1:0]    reg_rd_data,
    // output buffer write port
    output reg                   obuf_wr_reg,
    output reg  [`TGT_W-1:0]     obuf_target_reg,
    output reg  [`LANE_W-1:0]    obuf_lane_reg,
    output reg                   obuf_half_reg,
    output reg  [`DATA_W-1:0]    obuf_data_reg,
    // colour buffer valid mask and completion marks
    output reg                   valid_mask_wr_reg,
    output reg  [`LANES-1:0]     valid_mask_reg,
    output reg                   pixel_final_reg,
    output reg                   pos_final_reg
);

    // engine states, coded from the shared constants
    localparam [1:0] IDLE = `ST_IDLE;
    localparam [1:0] REQ  = `ST_REQ;
    localparam [1:0] SEND = `ST_SEND;
    localparam [1:0] FIN  = `ST_FIN;

    // classify a target code
    function [2:0] target_class;
        input [`TGT_W-1:0] t;
        begin
            if (t <= `TGT_COLOUR_LAST) begin
                target_class = `CLS_COLOUR;
            end else if (t == `TGT_DEPTH) begin
                target_class = `CLS_DEPTH;
            end else if (t == `TGT_NULL) begin
                target_class = `CLS_NULL;
            end else if (t >= `TGT_POS_FIRST && t <= `TGT_POS_LAST) begin
                target_class = `CLS_POS;
            end else if (t == `TGT_PRIM) begin
                target_class = `CLS_PRIM;
            end else if (t >= `TGT_PARAM_FIRST) begin
                target_class = `CLS_PARAM;
            end else begin
                target_class = `CLS_BAD;
            end
        end
    endfunction

    // lowest set lane of a mask
    // scanning downwards keeps the lowest bit, which fixes ascending lane order
    function [`LANE_W-1:0] first_lane;
        input [`LANES-1:0] m;
        integer i;
        begin
            first_lane = {`LANE_W{1'b0}};
            for (i = `LANES - 1; i >= 0; i = i - 1) begin
                if (m[i]) begin
                    first_lane = i[`LANE_W-1:0];
                end
            end
        end
    endfunction

    // pixel exports are colour, depth and the null target that only moves the mask
    function is_pixel_class;
        input [2:0] c;
        begin
            is_pixel_class = (c == `CLS_COLOUR) | (c == `CLS_DEPTH) | (c == `CLS_NULL);
        end
    endfunction

    // queue and issue wires
    wire [2:0]            issue_cls;
    wire                  q_ready;
    wire                  q_push;
    wire                  q_valid;
    wire                  q_pop;
    wire [`DESC_W-1:0]    q_in;
    wire [`DESC_W-1:0]    q_out;
    wire                  issue_take;
    wire                  finish;

    // engine state
    reg  [1:0]            state_reg;
    reg  [`DESC_W-1:0]    desc_reg;
    reg  [`LANES-1:0]     lanes_reg;
    wire [2:0]            cur_cls;
    wire [`TGT_W-1:0]     cur_target;
    wire [`LANE_W-1:0]    next_lane;
    wire [`LANES-1:0]     lanes_left;

    assign issue_cls  = target_class(instr_target);
    assign instr_ready = q_ready;
    assign issue_take = instr_valid & q_ready;
    // suppressed or undecodable exports are swallowed; an undecodable one only raises bad_target_reg
    assign q_push     = issue_take & ~export_suppress & (issue_cls != `CLS_BAD);
    // one descriptor packs every field the engine needs later
    assign q_in       = {instr_target, instr_valid_mask_flag, instr_final_flag,
                         instr_half_precision_flag, instr_reg_idx};
    assign q_pop      = q_valid & (state_reg == IDLE);

    assign cur_target = desc_reg[`DESC_TGT_HI:`DESC_TGT_LO];
    assign cur_cls    = target_class(cur_target);
    assign next_lane  = first_lane(lanes_reg);
    assign lanes_left = lanes_reg & ~(`LANES'h01 << next_lane);
    // last read has landed in the output buffer stage before the count drops
    assign finish     = (state_reg == FIN) & ~reg_rd_en_reg;

    // descriptors wait here, so many exports can be outstanding at once
    // a full queue pushes back through instr_ready; nothing is dropped
    export_queue #(
        .WIDTH (`DESC_W),
        .DEPTH (`QUEUE_DEPTH),
        .AW    (`QUEUE_AW)
    ) u_queue (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (q_push),
        .in_ready  (q_ready),
        .in_data   (q_in),
        .out_valid (q_valid),
        .out_ready (q_pop),
        .out_data  (q_out)
    );

    // pending count: up on selection, down after last data; both cancel
    // at most the queue depth plus one export in the engine, within five bits
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            export_pending_count_reg <= {`CNT_W{1'b0}};
        end else if (q_push && !finish) begin
            export_pending_count_reg <= export_pending_count_reg + 1'b1;
        end else if (finish && !q_push) begin
            export_pending_count_reg <= export_pending_count_reg - 1'b1;
        end
    end

    // flag an export whose target code falls in a hole of the map
    // the export itself is dropped, so the pending count never sees it
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bad_target_reg <= 1'b0;
        end else begin
            bad_target_reg <= issue_take & ~export_suppress & (issue_cls == `CLS_BAD);
        end
    end

    // bus engine: request, wait for grant, walk the enabled lanes, finish
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg         <= IDLE;
            desc_reg          <= {`DESC_W{1'b0}};
            lanes_reg         <= {`LANES{1'b0}};
            bus_req_reg       <= 1'b0;
            reg_rd_en_reg     <= 1'b0;
            reg_rd_idx_reg    <= {`REG_IDX_W{1'b0}};
            reg_rd_lane_reg   <= {`LANE_W{1'b0}};
            valid_mask_wr_reg <= 1'b0;
            valid_mask_reg    <= {`LANES{1'b0}};
            pixel_final_reg   <= 1'b0;
            pos_final_reg     <= 1'b0;
        end else begin
            reg_rd_en_reg     <= 1'b0;
            valid_mask_wr_reg <= 1'b0;
            pixel_final_reg   <= 1'b0;
            pos_final_reg     <= 1'b0;
            case (state_reg)
                IDLE: begin
                    // pop and load share one edge, so no descriptor is lost
                    if (q_valid) begin
                        desc_reg    <= q_out;
                        bus_req_reg <= 1'b1;
                        state_reg   <= REQ;
                    end
                end
                REQ: begin
                    // request holds until granted; the count cannot drop meanwhile
                    if (bus_gnt) begin
                        bus_req_reg    <= 1'b0;
                        reg_rd_idx_reg <= desc_reg[`DESC_REG_HI:`DESC_REG_LO];
                        // mask is sampled at grant, not at issue
                        lanes_reg      <= lane_enable_mask;
                        // an empty mask still publishes the valid mask
                        if (desc_reg[`DESC_VM]) begin
                            valid_mask_reg    <= lane_enable_mask;
                            valid_mask_wr_reg <= 1'b1;
                        end
                        if (cur_cls == `CLS_NULL || lane_enable_mask == {`LANES{1'b0}}) begin
                            state_reg <= FIN;
                        end else begin
                            state_reg <= SEND;
                        end
                    end
                end
                SEND: begin
                    // one enabled lane per cycle; disabled lanes are never read
                    // a full mask therefore costs eight cycles of reads
                    reg_rd_en_reg   <= 1'b1;
                    reg_rd_lane_reg <= next_lane;
                    lanes_reg       <= lanes_left;
                    if (lanes_left == {`LANES{1'b0}}) begin
                        state_reg <= FIN;
                    end
                end
                FIN: begin
                    // the last read is still in flight while the strobe is high
                    if (!reg_rd_en_reg) begin
                        // final flag only means something for pixel and position exports
                        if (desc_reg[`DESC_DONE]) begin
                            pixel_final_reg <= is_pixel_class(cur_cls);
                            pos_final_reg   <= (cur_cls == `CLS_POS);
                        end
                        state_reg <= IDLE;
                    end
                end
                default: begin
                    // unreachable with four states; kept so a glitch returns to idle
                    state_reg   <= IDLE;
                    bus_req_reg <= 1'b0;
                end
            endcase
        end
    end

    // output buffer stage: data returned in the read strobe's own cycle, written a cycle after the read
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            obuf_wr_reg     <= 1'b0;
            obuf_target_reg <= {`TGT_W{1'b0}};
            obuf_lane_reg   <= {`LANE_W{1'b0}};
            obuf_half_reg   <= 1'b0;
            obuf_data_reg   <= {`DATA_W{1'b0}};
        end else begin
            // each write adds to the buffer; this unit never clears it
            obuf_wr_reg <= reg_rd_en_reg;
            if (reg_rd_en_reg) begin
                obuf_target_reg <= cur_target;
                obuf_lane_reg   <= reg_rd_lane_reg;
                obuf_half_reg   <= desc_reg[`DESC_HALF];
                if (desc_reg[`DESC_HALF]) begin
                    // four 16-bit components packed low; the upper 64 bits are written as zero
                    obuf_data_reg <= {{(`DATA_W - 4 * `HALF_W){1'b0}},
                                      reg_rd_data[3*`COMP_W +: `HALF_W],
                                      reg_rd_data[2*`COMP_W +: `HALF_W],
                                      reg_rd_data[1*`COMP_W +: `HALF_W],
                                      reg_rd_data[0 +: `HALF_W]};
                end else begin
                    // red, green, blue, alpha as four 32-bit words
                    obuf_data_reg <= reg_rd_data;
                end
            end
        end
    end

endmodule

// ===== shader_export_unit_props.sv
// Purpose: temporal checks on the export unit ports
// Assumes: one clock domain, reset asynchronous and active low
// Notes:   bound from the bench top file
`timescale 1ns/1ns
`include "shader_export_consts.vh"
module shader_export_unit_props (
    // clock and reset
    input wire                  clk,
    input wire                  arst_n,
    // issue side
    input wire                  instr_valid,
    input wire                  instr_ready,
    input wire [`TGT_W-1:0]     instr_target,
    input wire                  export_suppress,
    input wire [`LANES-1:0]     lane_enable_mask,
    // engine and output side
    input wire [`CNT_W-1:0]     export_pending_count_reg,
    input wire                  bad_target_reg,
    input wire                  bus_req_reg,
    input wire                  bus_gnt,
    input wire                  reg_rd_en_reg,
    input wire [`LANE_W-1:0]    reg_rd_lane_reg,
    input wire                  obuf_wr_reg,
    input wire [`TGT_W-1:0]     obuf_target_reg,
    input wire [`LANE_W-1:0]    obuf_lane_reg,
    input wire                  obuf_half_reg,
    input wire [`DATA_W-1:0]    obuf_data_reg,
    input wire                  valid_mask_wr_reg,
    input wire [`LANES-1:0]     valid_mask_reg,
    input wire                  pixel_final_reg,
    input wire                  pos_final_reg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // while the engine waits for the bus no export can finish
    wire take     = instr_valid && instr_ready;
    wire wait_gnt = bus_req_reg && !bus_gnt;
    wire [`CNT_W-1:0] cnt = export_pending_count_reg;

    a_req_holds: assert property (wait_gnt |=> bus_req_reg)
        else $error("bus request dropped before grant");
    a_count_waits: assert property (wait_gnt && !instr_valid |=> $stable(cnt))
        else $error("pending count moved while waiting for grant");
    a_req_drops: assert property (bus_req_reg && bus_gnt |=> !bus_req_reg)
        else $error("bus request still high after grant");
    a_count_rises: assert property (take && !export_suppress && instr_target >= 6'h20
        && wait_gnt |=> cnt == $past(cnt) + 5'h01) else $error("count did not rise on issue");
    a_suppress_nop: assert property (take && export_suppress && wait_gnt |=> $stable(cnt))
        else $error("suppressed export changed the count");
    a_write_after_read: assert property (obuf_wr_reg |-> $past(reg_rd_en_reg)
        && obuf_lane_reg == $past(reg_rd_lane_reg)) else $error("write without matching read");
    a_null_no_write: assert property (obuf_wr_reg |-> obuf_target_reg != `TGT_NULL)
        else $error("null target wrote the output buffer");
    a_half_upper: assert property (obuf_wr_reg && obuf_half_reg |-> obuf_data_reg[127:64] == 64'h0)
        else $error("half precision upper bits not zero");
    a_mask_at_grant: assert property (valid_mask_wr_reg |-> $past(bus_req_reg) && $past(bus_gnt)
        && valid_mask_reg == $past(lane_enable_mask)) else $error("valid mask not taken at grant");
    a_final_dec: assert property ((pixel_final_reg || pos_final_reg) && !$past(instr_valid)
        |-> cnt == $past(cnt) - 5'h01) else $error("finish did not lower the count");
    a_bad_target: assert property (take && !export_suppress && instr_target inside
        {[6'h0A:6'h0B], [6'h11:6'h13], [6'h15:6'h1F]} |=> bad_target_reg)
        else $error("unmapped target not flagged");
    // main scenarios reached
    c_queue_full: cover property (instr_valid && !instr_ready);
    c_half_write: cover property (obuf_wr_reg && obuf_half_reg);
    c_empty_mask: cover property (valid_mask_wr_reg && valid_mask_reg == 8'h00);
    c_pos_final: cover property (pos_final_reg);
endmodule

// ===== export_far_side.sv
// Purpose: model of the bus arbiter and register file read port
// Assumes: grant after a set number of waiting cycles
// Notes:   read data stands in the strobe's own cycle; the unit takes it at the closing edge
`timescale 1ns/1ns
`include "shader_export_consts.vh"
module export_far_side (
    // clock and reset
    input  wire                  clk,
    input  wire                  arst_n,
    // bus arbitration
    input  wire                  bus_req_reg,
    output reg                   bus_gnt,
    input  wire [3:0]            gnt_delay,
    // register file read port
    input  wire                  reg_rd_en_reg,
    input  wire [`REG_IDX_W-1:0] reg_rd_idx_reg,
    input  wire [`LANE_W-1:0]    reg_rd_lane_reg,
    output wire [`DATA_W-1:0]    reg_rd_data
);
    reg  [3:0]            wait_cnt;
    reg  [`DATA_W-1:0]    last_q;
    wire [`REG_IDX_W-1:0] ix = reg_rd_idx_reg;
    wire [`LANE_W-1:0]    ln = reg_rd_lane_reg;
    wire [`DATA_W-1:0]    word = {ix, 5'h00, ln, 8'h03, ~ix, ix, 5'h00, ln, 8'h02, ~ix,
                                  ix, 5'h00, ln, 8'h01, ~ix, ix, 5'h00, ln, 8'h00, ~ix};
    // grant after gnt_delay plus one waiting cycles, one pulse per request
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_gnt  <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (bus_req_reg && !bus_gnt) begin
            wait_cnt <= wait_cnt + 4'h1;
            bus_gnt  <= (wait_cnt >= gnt_delay);
        end else begin
            bus_gnt  <= 1'b0;
            wait_cnt <= 4'h0;
        end
    end
    // data stands while the strobe is high, then the inverse so stale values never match
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            last_q <= 128'h0;
        else if (reg_rd_en_reg)
            last_q <= word;
    end
    assign reg_rd_data = reg_rd_en_reg ? word : ~last_q;
endmodule

// ===== shader_export_unit_bench.sv
// Purpose: self-checking bench for the shader export unit
// Assumes: lane mask changes only once the pending count is zero
// Notes:   random exports from a fixed seed, with swept target codes
`timescale 1ns/1ns
`include "shader_export_consts.vh"
module shader_export_unit_bench;
    reg clk = 1'b0, arst_n = 1'b0, instr_valid = 1'b0, export_suppress = 1'b0;
    reg instr_valid_mask_flag = 1'b0, instr_final_flag = 1'b0, instr_half_precision_flag = 1'b0;
    reg [5:0] instr_target = 6'h00, t;
    reg [7:0] instr_reg_idx = 8'h00, lane_enable_mask = 8'h00;
    reg [3:0] gnt_delay = 4'h0;
    reg vm_force = 1'b0, fin_force = 1'b0;
    reg [31:0] r;
    reg [137:0] e, exp_q[$];
    wire instr_ready, bad_target_reg, bus_req_reg, bus_gnt, reg_rd_en_reg, obuf_wr_reg;
    wire obuf_half_reg, valid_mask_wr_reg, pixel_final_reg, pos_final_reg;
    wire [4:0] export_pending_count_reg;
    wire [7:0] reg_rd_idx_reg, valid_mask_reg;
    wire [2:0] reg_rd_lane_reg, obuf_lane_reg;
    wire [5:0] obuf_target_reg;
    wire [127:0] reg_rd_data, obuf_data_reg;
    integer seed = 32'h89396022;
    integer fails = 0, compares = 0, cycles = 0, i, n, k;
    integer pf_exp = 0, pf_got = 0, ps_exp = 0, ps_got = 0, bd_exp = 0, bd_got = 0;
    integer vm_exp = 0, vm_got = 0;
    shader_export_unit DUT (.*);
    export_far_side far_side (.*);
    initial forever #4 clk = ~clk;
    // expected write: target, lane, half flag, data with component 0 lowest
    function [137:0] exp_word(input [5:0] tg, input [7:0] ix, input [2:0] ln, input hf);
        reg [127:0] f, h;
        begin
            h = 128'h0;
            for (k = 0; k < 4; k = k + 1) begin
                f[32*k +: 32] = {ix, 5'h00, ln, k[7:0], ~ix};
                h[16*k +: 16] = {k[7:0], ~ix};
            end
            exp_word = {tg, ln, hf, hf ? h : f};
        end
    endfunction
    function mapped(input [5:0] tg);
        mapped = tg <= 6'h09 || (tg >= 6'h0C && tg <= 6'h10) || tg == 6'h14 || tg >= 6'h20;
    endfunction
    task chk_word(input [137:0] got, input [137:0] want);
        begin
            compares = compares + 1;
            if (got !== want) begin
                fails = fails + 1;
                $display("[FAIL] %0t got=%h want=%h", $time, got, want);
            end
        end
    endtask
    task chk_num(input [31:0] got, input [31:0] want);
        begin
            compares = compares + 1;
            if (got !== want) begin
                fails = fails + 1;
                $display("[FAIL] %0t got=%h want=%h", $time, got, want);
            end
        end
    endtask
    // offer one export and hold it until taken; flags only where they mean something
    task issue(input [5:0] tg);
        begin
            r = $random(seed);
            instr_valid = 1'b1;
            instr_target = tg;
            instr_reg_idx = r[7:0];
            instr_half_precision_flag = r[8];
            instr_valid_mask_flag = (r[9] || vm_force) && tg <= 6'h09;
            instr_final_flag = (r[10] || fin_force) && tg <= 6'h10 && !(tg > 6'h09 && tg < 6'h0C);
            while (instr_ready !== 1'b1) @(posedge clk) #1;
            @(posedge clk) #1;
            if (!export_suppress && mapped(tg)) begin
                for (i = 0; i < 8; i = i + 1)
                    if (lane_enable_mask[i] && tg != 6'h09)
                        exp_q.push_back(exp_word(tg, instr_reg_idx, i[2:0], r[8]));
                pf_exp = pf_exp + (instr_final_flag && tg <= 6'h09);
                ps_exp = ps_exp + (instr_final_flag && tg >= 6'h0C);
                vm_exp = vm_exp + instr_valid_mask_flag;
            end
            bd_exp = bd_exp + (!export_suppress && !mapped(tg));
        end
    endtask
    task phase(input [7:0] m, input [3:0] d, input s, input integer cnt, input sweep);
        begin
            lane_enable_mask = m;
            gnt_delay = d;
            export_suppress = s;
            for (n = 0; n < cnt; n = n + 1) begin
                t = sweep ? n[5:0] : $random(seed);
                issue(s ? (t | 6'h20) : t);
            end
            instr_valid = 1'b0;
            for (i = 0; i < 3000 && (export_pending_count_reg !== 5'h00 || exp_q.size()); i++)
                @(posedge clk) #1;
            repeat (4) @(posedge clk);
            #1;
            chk_num(export_pending_count_reg, 32'h0);
            chk_num(exp_q.size(), 32'h0);
            chk_num(pf_got, pf_exp);
            chk_num(ps_got, ps_exp);
            chk_num(bd_got, bd_exp);
            chk_num(vm_got, vm_exp);
        end
    endtask
    task print_verdict;
        begin
            $display("compares=%0d fails=%0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // monitor of the output side and the timeout
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (obuf_wr_reg === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : {138{1'b1}};
            chk_word({obuf_target_reg, obuf_lane_reg, obuf_half_reg, obuf_data_reg}, e);
        end
        if (valid_mask_wr_reg === 1'b1) begin
            vm_got = vm_got + 1;
            chk_num(valid_mask_reg, lane_enable_mask);
        end
        pf_got = pf_got + (pixel_final_reg === 1'b1);
        ps_got = ps_got + (pos_final_reg === 1'b1);
        bd_got = bd_got + (bad_target_reg === 1'b1);
        if (cycles == 20000) begin
            fails = fails + 1;
            print_verdict;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        @(posedge clk) #1;
        // hand-written programs; space for the primitive export counts as granted
        lane_enable_mask = 8'h3C;
        vm_force = 1'b1;
        issue(6'h01);
        fin_force = 1'b1;
        issue(6'h09);
        vm_force = 1'b0;
        issue(6'h0C);
        fin_force = 1'b0;
        issue(6'h21);
        issue(6'h14);
        phase(8'h3C, 4'h3, 1'b0, 0, 1'b0);
        phase(8'hFF, 4'h0, 1'b0, 64, 1'b1);
        phase(8'h5A, 4'hF, 1'b0, 24, 1'b0);
        phase(8'h00, 4'h2, 1'b0, 12, 1'b0);
        phase(8'h81, 4'h1, 1'b1, 6, 1'b0);
        repeat (3) begin
            r = $random(seed);
            phase(r[7:0], r[11:8], 1'b0, 20, 1'b0);
        end
        print_verdict;
    end
endmodule
bind shader_export_unit shader_export_unit_props props_i (.*);
